// *** common/serial_rx_pkg.sv ***
// Shared constants and carriers for the serial receive buffer and port status block.
// Assumes one clock domain; command blocks arrive already gathered into one packed word.
package serial_rx_pkg;

	// Command numbers (hex form of the decimal command codes)
	localparam logic [15:0] CMD_SETUP_BUF = 16'h10CD;
	localparam logic [15:0] CMD_FLUSH_BUF = 16'h10CE;
	localparam logic [15:0] CMD_PORT_STATUS = 16'h10CF;

	// Data block length expected with each command
	localparam logic [15:0] LEN_SETUP_BUF = 16'h0002;
	localparam logic [15:0] LEN_FLUSH_BUF = 16'h0001;
	localparam logic [15:0] LEN_PORT_STATUS = 16'h0003;

	// Receive buffer sizing, in bytes
	localparam int BUF_MAX_BYTES = 2048;
	localparam int BUF_DEFAULT_BYTES = 2048;
	localparam int BYTES_PER_WORD_SHIFT = 1;

	// Port status word bit positions
	localparam int BIT_READ_IN_PROGRESS = 15;
	localparam int BIT_READ_SUCCESS = 14;
	localparam int BIT_READ_TIMEOUT = 13;
	localparam int BIT_WRITE_IN_PROGRESS = 12;
	localparam int BIT_WRITE_SUCCESS = 11;
	localparam int BIT_WRITE_TIMEOUT = 10;
	localparam int BIT_CHAR_AVAILABLE = 9;
	localparam int BIT_OVERFLOW_ERROR = 8;
	localparam int BIT_FRAMING_ERROR = 7;
	localparam int BIT_PARITY_ERROR = 6;
	localparam int BIT_CTS_ACTIVE = 5;
	localparam int UNUSED_BITS_MSB = 4;

	// Reset values
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Answer codes
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_BAD_CMD = 8'h01;
	localparam logic [7:0] ERR_BAD_LEN = 8'h02;
	localparam logic [7:0] ERR_TOO_BIG = 8'h03;

	// Command block, first word in the top bits
	typedef struct packed {
		logic [15:0] data_len;
		logic [15:0] immediate_return_mode;
		logic [15:0] status_mem_type;
		logic [15:0] status_addr_m1;
		logic [15:0] unused_a;
		logic [15:0] unused_b;
		logic [15:0] cmd_num;
		logic [15:0] param_a;
		logic [15:0] param_b;
	} cmd_block_t;

	// One character from the serial receiver with its line errors
	typedef struct packed {
		logic [7:0] data;
		logic framing_error;
		logic parity_error;
		logic overrun;
	} rx_char_t;

	// Answer to a command: where to write, then the two result words
	typedef struct packed {
		logic [15:0] mem_type;
		logic [15:0] mem_offset;
		logic [15:0] status;
		logic [15:0] avail;
	} result_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} cmd_state_t;

endpackage

// *** hdl/serial_rx_buffer_port_status.sv ***
// Receive buffer and port status logic of a raw serial I/O port.
// Assumes a serial receiver and transmitter on ref_clk reporting events as one-cycle
// pulses, and a command sequencer presenting whole command blocks.
`timescale 1ns/1ps
`default_nettype none

module serial_rx_buffer_port_status
	import serial_rx_pkg::*;
#(
	parameter int BUF_BYTES = BUF_MAX_BYTES,
	parameter bit HAS_CTS = 1'b1
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic cmd_valid, // Command block offered
	input wire cmd_block_t cmd_block, // Command block words
	output logic cmd_ready_q, // Ready to take a command
	output logic resp_valid_q, // Answer pulse
	output logic [7:0] resp_error_q, // Answer code
	output result_t resp_result_q, // Destination and result words
	input wire logic rx_valid, // Received character pulse
	input wire rx_char_t rx_char, // Received character and errors
	input wire logic cts_line, // CTS pin, active high, asynchronous
	input wire logic rd_start, // Read bytes or string started
	input wire logic [15:0] rd_len, // Characters the read wants
	input wire logic rd_timeout, // Receive time-out pulse
	input wire logic rd_cancel, // Read cancelled pulse
	output logic rd_data_valid_q, // Character delivered to a read
	output logic [7:0] rd_data_q, // Delivered character
	input wire logic wr_start, // Write bytes started
	input wire logic wr_done, // Write finished
	input wire logic wr_timeout, // Transmit time-out pulse
	input wire logic wr_cancel, // Write cancelled pulse
	output logic [15:0] serial_port_status_word_q, // Live status word
	output logic [15:0] receive_characters_available_q, // Unread characters
	output logic [15:0] buffer_capacity_q // Current capacity in bytes
);

	localparam int AW = $clog2(BUF_BYTES);
	localparam int CW = $clog2(BUF_BYTES + 1);
	localparam logic [16:0] CAP_LIMIT = 17'(BUF_BYTES);
	localparam logic [CW-1:0] CAP_DEFAULT = CW'(BUF_DEFAULT_BYTES);

	logic rst_meta_q, rst_n, cts_meta_q, cts_sync_q, cts_active;
	cmd_state_t state_q;
	cmd_block_t cmd_q;
	logic [7:0] mem [0:BUF_BYTES-1];
	logic [AW-1:0] wr_ptr_q, rd_ptr_q;
	logic [CW-1:0] count_q, cap_q;
	logic rd_busy_q, rd_ok_q, rd_to_q, wr_busy_q, wr_ok_q, wr_to_q, of_q, fe_q, pe_q;
	logic [15:0] rd_remain_q, status_live;
	logic in_exec, exec_setup, exec_flush, exec_status, push, pop, full, of_set, fe_set, pe_set;
	logic [16:0] req_bytes;
	logic [7:0] exec_err;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// CTS pin synchroniser; only the second flop is read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cts_meta_q <= 1'b0;
			cts_sync_q <= 1'b0;
		end else begin
			cts_meta_q <= cts_line;
			cts_sync_q <= cts_meta_q;
		end
	end

	// A port built without a CTS line always reports it active
	assign cts_active = !HAS_CTS || cts_sync_q;

	// Command sequencer: take a block in idle, execute it in the next cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cmd_ready_q <= 1'b0;
			cmd_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cmd_ready_q <= 1'b1;
					// Only a block offered while ready is taken, so none slips in after reset
					if (cmd_valid && cmd_ready_q) begin
						state_q <= ST_EXEC;
						cmd_ready_q <= 1'b0;
						cmd_q <= cmd_block;
					end
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
					cmd_ready_q <= 1'b1;
				end
				default: begin
					state_q <= ST_IDLE;
					cmd_ready_q <= 1'b0;
				end
			endcase
		end
	end

	assign in_exec = (state_q == ST_EXEC);
	// Length arrives in 16-bit words; two bytes per word
	assign req_bytes = {1'b0, cmd_q.param_a} << BYTES_PER_WORD_SHIFT;

	// Decode the held block; the length word must match the command
	always_comb begin
		exec_err = ERR_NONE;
		if (cmd_q.cmd_num == CMD_SETUP_BUF) begin
			if (cmd_q.data_len != LEN_SETUP_BUF) begin
				exec_err = ERR_BAD_LEN;
			end else if (req_bytes > CAP_LIMIT) begin
				exec_err = ERR_TOO_BIG;
			end
		end else if (cmd_q.cmd_num == CMD_FLUSH_BUF && cmd_q.data_len != LEN_FLUSH_BUF) begin
			exec_err = ERR_BAD_LEN;
		end else if (cmd_q.cmd_num == CMD_PORT_STATUS && cmd_q.data_len != LEN_PORT_STATUS) begin
			exec_err = ERR_BAD_LEN;
		end else if (cmd_q.cmd_num != CMD_FLUSH_BUF && cmd_q.cmd_num != CMD_PORT_STATUS) begin
			exec_err = ERR_BAD_CMD;
		end
	end

	assign exec_setup = in_exec && (cmd_q.cmd_num == CMD_SETUP_BUF) && (exec_err == ERR_NONE);
	assign exec_flush = in_exec && (cmd_q.cmd_num == CMD_FLUSH_BUF) && (exec_err == ERR_NONE);
	assign exec_status = in_exec && (cmd_q.cmd_num == CMD_PORT_STATUS) && (exec_err == ERR_NONE);

	// Capacity register; a refused resize leaves the old size in place
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_q <= CAP_DEFAULT;
		end else if (exec_setup) begin
			cap_q <= (cmd_q.param_a == 16'h0000) ? CAP_DEFAULT : req_bytes[CW-1:0];
		end
	end

	// Buffer traffic; a character arriving during a flush is discarded with the rest
	assign full = (count_q >= cap_q);
	assign push = rx_valid && !full && !exec_flush;
	assign pop = rd_busy_q && (rd_remain_q != 16'h0000) && (count_q != '0) && !exec_flush
		&& !rd_cancel && !rd_timeout;

	// Character storage; no reset needed, the pointers guard it
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= rx_char.data;
		end
	end

	// Pointers and fill count; pointers wrap over the full array, capacity only limits count
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (exec_flush) begin
			rd_ptr_q <= wr_ptr_q;
			count_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_q + CW'(push) - CW'(pop);
		end
	end

	// The only way out of the buffer besides a flush: characters handed to an active read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			rd_data_valid_q <= pop;
			rd_data_q <= pop ? mem[rd_ptr_q] : rd_data_q;
		end
	end

	// Read progress; a start while busy is ignored, cancel beats time-out beats success
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_busy_q <= 1'b0;
			rd_ok_q <= 1'b0;
			rd_to_q <= 1'b0;
			rd_remain_q <= 16'h0000;
		end else if (!rd_busy_q) begin
			if (rd_start) begin
				rd_busy_q <= 1'b1;
				rd_ok_q <= 1'b0;
				rd_to_q <= 1'b0;
				rd_remain_q <= rd_len;
			end
		end else if (rd_cancel) begin
			rd_busy_q <= 1'b0;
		end else if (rd_timeout) begin
			rd_busy_q <= 1'b0;
			rd_to_q <= 1'b1;
		end else if (rd_remain_q == 16'h0000) begin
			rd_busy_q <= 1'b0;
			rd_ok_q <= 1'b1;
		end else if (pop) begin
			rd_remain_q <= rd_remain_q - 16'h0001;
		end
	end

	// Write progress, kept apart from the read flags so both completions can show
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy_q <= 1'b0;
			wr_ok_q <= 1'b0;
			wr_to_q <= 1'b0;
		end else if (wr_start) begin
			wr_busy_q <= 1'b1;
			wr_ok_q <= 1'b0;
			wr_to_q <= 1'b0;
		end else if (wr_busy_q) begin
			if (wr_cancel) begin
				wr_busy_q <= 1'b0;
			end else if (wr_timeout) begin
				wr_busy_q <= 1'b0;
				wr_to_q <= 1'b1;
			end else if (wr_done) begin
				wr_busy_q <= 1'b0;
				wr_ok_q <= 1'b1;
			end
		end
	end

	// Line and buffer error events
	assign of_set = rx_valid && (rx_char.overrun || (full && !exec_flush));
	assign fe_set = rx_valid && rx_char.framing_error;
	assign pe_set = rx_valid && rx_char.parity_error;

	// Sticky error flags; a new event in the clearing cycle survives the query
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			of_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
		end else begin
			of_q <= of_set || (of_q && !exec_status);
			fe_q <= fe_set || (fe_q && !exec_status);
			pe_q <= pe_set || (pe_q && !exec_status);
		end
	end

	// Assemble the status word; low bits are tied to zero
	always_comb begin
		status_live = STATUS_RESET;
		status_live[BIT_READ_IN_PROGRESS] = rd_busy_q;
		status_live[BIT_READ_SUCCESS] = rd_ok_q;
		status_live[BIT_READ_TIMEOUT] = rd_to_q;
		status_live[BIT_WRITE_IN_PROGRESS] = wr_busy_q;
		status_live[BIT_WRITE_SUCCESS] = wr_ok_q;
		status_live[BIT_WRITE_TIMEOUT] = wr_to_q;
		status_live[BIT_CHAR_AVAILABLE] = (count_q != '0);
		status_live[BIT_OVERFLOW_ERROR] = of_q;
		status_live[BIT_FRAMING_ERROR] = fe_q;
		status_live[BIT_PARITY_ERROR] = pe_q;
		status_live[BIT_CTS_ACTIVE] = cts_active;
	end

	// Mirror registers of the block state, one cycle behind the flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_port_status_word_q <= STATUS_RESET;
			receive_characters_available_q <= COUNT_RESET;
			buffer_capacity_q <= 16'(BUF_DEFAULT_BYTES);
		end else begin
			serial_port_status_word_q <= status_live;
			receive_characters_available_q <= 16'(count_q);
			buffer_capacity_q <= 16'(cap_q);
		end
	end

	// Answer; result words are filled only by a status query
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_valid_q <= 1'b0;
			resp_error_q <= ERR_NONE;
			resp_result_q <= '0;
		end else begin
			resp_valid_q <= in_exec;
			if (in_exec) begin
				resp_error_q <= exec_err;
				resp_result_q <= '0;
				if (exec_status) begin
					resp_result_q.mem_type <= cmd_q.param_a;
					resp_result_q.mem_offset <= cmd_q.param_b;
					resp_result_q.status <= status_live;
					resp_result_q.avail <= 16'(count_q);
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_resize_zero_default: assert property (exec_setup && cmd_q.param_a == 16'h0000
		|=> cap_q == CAP_DEFAULT) else $error("zero resize did not restore default");
	a_resize_too_big: assert property (in_exec && cmd_q.cmd_num == CMD_SETUP_BUF
		&& cmd_q.data_len == LEN_SETUP_BUF && req_bytes > CAP_LIMIT
		|=> resp_valid_q && resp_error_q == ERR_TOO_BIG && cap_q == $past(cap_q))
		else $error("oversize resize not refused");
	a_flush_empties: assert property (exec_flush |=> count_q == '0 ##1
		!receive_characters_available_q[0] && receive_characters_available_q == 16'h0000)
		else $error("flush left characters");
	a_status_result: assert property (exec_status |=> resp_valid_q
		&& resp_result_q.status == $past(status_live)
		&& resp_result_q.avail == 16'($past(count_q))) else $error("status result wrong");
	a_read_start: assert property (rd_start && !rd_busy_q
		|=> rd_busy_q && !rd_ok_q && !rd_to_q) else $error("read start flags wrong");
	a_read_timeout: assert property (rd_busy_q && !rd_cancel && rd_timeout
		|=> !rd_busy_q && rd_to_q && !rd_ok_q) else $error("read time-out not flagged");
	a_write_done: assert property (wr_busy_q && !wr_start && !wr_cancel && !wr_timeout
		&& wr_done |=> !wr_busy_q && wr_ok_q ##1 serial_port_status_word_q[BIT_WRITE_SUCCESS])
		else $error("write success not flagged");
	a_avail_bit: assert property (count_q != '0 && !exec_flush && !pop
		|=> serial_port_status_word_q[BIT_CHAR_AVAILABLE]) else $error("char available low");
	a_overflow_sticky: assert property (rx_valid && full && !exec_flush && !exec_status
		|=> of_q && count_q == $past(count_q) - CW'($past(pop))
		##1 serial_port_status_word_q[BIT_OVERFLOW_ERROR]) else $error("overflow not flagged");
	a_framing_clear: assert property (exec_status && !fe_set |=> !fe_q)
		else $error("framing flag not cleared");
	a_unused_zero: assert property (##1
		serial_port_status_word_q[UNUSED_BITS_MSB:0] == 5'h00)
		else $error("unused status bits set");

	c_both_done: cover property (exec_status && rd_ok_q && wr_ok_q);
	c_flush_full: cover property (exec_flush && count_q != '0);
	c_read_delivers: cover property (pop ##1 pop ##1 rd_busy_q && rd_remain_q == 16'h0000);
	c_overflow: cover property (of_set && full);

endmodule

`default_nettype wire

// *** tb/serial_device_model.sv ***
// Behavioural model of the serial device on the far side of the receive port.
// Assumes the bench asks for one character per send pulse, all on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module serial_device_model
	import serial_rx_pkg::*;
(
	input wire logic ref_clk, // Bench clock
	input wire logic send, // Send one character now
	input wire rx_char_t char_in, // Character and line errors to send
	input wire logic cts_in, // CTS level wanted
	output logic rx_valid, // Character strobe
	output rx_char_t rx_char, // Character towards the port
	output logic cts_line // CTS pin
);
	// Known levels before the first edge
	initial begin
		rx_valid = 1'b0;
		rx_char = '0;
		cts_line = 1'b1;
	end

	// Between characters the data toggles, so a stale value can never pass for a new one
	always @(posedge ref_clk) begin
		rx_valid <= send;
		rx_char <= send ? char_in : ~rx_char;
		cts_line <= cts_in;
	end
endmodule

`default_nettype wire

// *** tb/serial_rx_buffer_port_status_bench.sv ***
// Self-checking bench for the receive buffer and port status block.
// Assumes the serial device model beside it and the package constants.
`timescale 1ns/1ps
`default_nettype none

module serial_rx_buffer_port_status_bench;
	import serial_rx_pkg::*;
	logic ref_clk, rst_b, cmd_valid, snd, cts_in, rx_valid, cts_line;
	logic cmd_ready_q, resp_valid_q, rd_data_valid_q;
	cmd_block_t cmd_block;
	rx_char_t sch, rx_char;
	result_t resp_result_q;
	logic [6:0] ev;
	logic [15:0] rd_len, stat_q, avail_q, cap_q;
	logic [7:0] resp_error_q, rd_data_q;
	logic [7:0] exp_q[$];
	int failures, samples_checked, seed, n;
	// Event order: rd_start, rd_timeout, rd_cancel, wr_start, wr_done, wr_timeout, wr_cancel
	int seq_ev [13] = '{0, 1, 0, 2, 3, 4, 3, 5, 3, 6, 3, 0, 4};
	logic [15:0] seq_st [13] = '{16'h8020, 16'h2020, 16'h8020, 16'h0020, 16'h1020, 16'h0820,
		16'h1020, 16'h0420, 16'h1020, 16'h0020, 16'h1020, 16'h5020, 16'h4820};

	serial_rx_buffer_port_status serial_rx_buffer_port_status_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_block(cmd_block),
		.cmd_ready_q(cmd_ready_q), .resp_valid_q(resp_valid_q), .resp_error_q(resp_error_q),
		.resp_result_q(resp_result_q), .rx_valid(rx_valid), .rx_char(rx_char),
		.cts_line(cts_line), .rd_start(ev[0]), .rd_len(rd_len), .rd_timeout(ev[1]),
		.rd_cancel(ev[2]), .rd_data_valid_q(rd_data_valid_q), .rd_data_q(rd_data_q),
		.wr_start(ev[3]), .wr_done(ev[4]), .wr_timeout(ev[5]), .wr_cancel(ev[6]),
		.serial_port_status_word_q(stat_q), .receive_characters_available_q(avail_q),
		.buffer_capacity_q(cap_q)
	);

	serial_device_model serial_device_model_i (
		.ref_clk(ref_clk), .send(snd), .char_in(sch), .cts_in(cts_in),
		.rx_valid(rx_valid), .rx_char(rx_char), .cts_line(cts_line)
	);

	// Clock at 10 MHz
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Counts, verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_code(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// A wait that ran out ends the run at once
	task automatic hang(input string what);
		failures++;
		$display("Error %s expected a pulse seen none", what);
		test_done();
	endtask

	// Offer one command block, hold it until taken, then check the answer code
	task automatic cmd(input logic [15:0] num, len, pa, pb, input logic [7:0] err);
		int k;
		k = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_block <= {len, 16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0000, num, pa, pb};
		do begin
			@(posedge ref_clk);
			k++;
		end while (cmd_ready_q !== 1'b1 && k < 20);
		if (k >= 20) hang("cmd_ready_q");
		cmd_valid <= 1'b0;
		// The answer pulse stands only in the cycle after the execute cycle
		@(posedge ref_clk);
		#1;
		chk_word("resp_valid_q", 16'h0001, {15'h0000, resp_valid_q});
		chk_code("resp_error_q", err, resp_error_q);
	endtask

	// Status query; the echoed destination and both result words are compared
	task automatic query(input logic [15:0] st, input logic [15:0] av);
		cmd(CMD_PORT_STATUS, LEN_PORT_STATUS, 16'h004C, 16'h0065, ERR_NONE);
		chk_word("result mem_type", 16'h004C, resp_result_q.mem_type);
		chk_word("result mem_offset", 16'h0065, resp_result_q.mem_offset);
		chk_word("result status", st, resp_result_q.status);
		chk_word("result avail", av, resp_result_q.avail);
	endtask

	// One-cycle pulse on one read or write event line
	task automatic pulse(input int b, input logic [15:0] len);
		@(posedge ref_clk);
		ev <= 7'h01 << b;
		rd_len <= len;
		@(posedge ref_clk);
		ev <= 7'h00;
	endtask

	// One random character from the device; kept ones are expected back in order
	task automatic send(input logic fe, input logic pe, input bit keep);
		logic [7:0] d;
		d = 8'($random(seed));
		if (keep) exp_q.push_back(d);
		@(posedge ref_clk);
		snd <= 1'b1;
		// Both line errors together also report a receiver overrun
		sch <= {d, fe, pe, fe && pe};
		@(posedge ref_clk);
		snd <= 1'b0;
	endtask

	// Let flags and their registered copies settle, then compare the live outputs
	task automatic live(input logic [15:0] st, input logic [15:0] av);
		repeat (5) @(posedge ref_clk);
		#1;
		chk_word("serial_port_status_word_q", st, stat_q);
		chk_word("receive_characters_available_q", av, avail_q);
	endtask

	task automatic cap_is(input logic [15:0] exp);
		repeat (3) @(posedge ref_clk);
		#1;
		chk_word("buffer_capacity_q", exp, cap_q);
	endtask

	// Every expected character must come out of a read, one pulse each
	task automatic collect();
		int k;
		while (exp_q.size() > 0) begin
			k = 0;
			do begin
				@(posedge ref_clk);
				#1;
				k++;
			end while (rd_data_valid_q !== 1'b1 && k < 20);
			if (k >= 20) hang("rd_data_valid_q");
			chk_word("rd_data_q", {8'h00, exp_q.pop_front()}, {8'h00, rd_data_q});
		end
	endtask

	initial begin
		seed = 32'h0a515d44;
		failures = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_block = '0;
		ev = 7'h00;
		rd_len = 16'h0000;
		snd = 1'b0;
		sch = '0;
		cts_in = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		live(16'h0020, 16'h0000);
		cap_is(16'h0800);
		$display("test reset done");
		// Unknown command and wrong lengths change nothing
		cmd(16'h10CC, 16'h0001, 16'h0000, 16'h0000, ERR_BAD_CMD);
		cmd(CMD_SETUP_BUF, 16'h0003, 16'h0008, 16'h0000, ERR_BAD_LEN);
		cmd(CMD_FLUSH_BUF, 16'h0002, 16'h0000, 16'h0000, ERR_BAD_LEN);
		cmd(CMD_PORT_STATUS, 16'h0002, 16'h004C, 16'h0065, ERR_BAD_LEN);
		cap_is(16'h0800);
		$display("test refusals done");
		// The read asks one more than is buffered, so it stays busy until the last arrives
		n = 2 + ($random(seed) & 3);
		for (int i = 0; i < n; i++) send(1'b0, 1'b0, 1'b1);
		live(16'h0220, 16'(n));
		query(16'h0220, 16'(n));
		pulse(0, 16'(n + 1));
		collect();
		live(16'h8020, 16'h0000);
		send(1'b0, 1'b0, 1'b1);
		collect();
		live(16'h4020, 16'h0000);
		$display("test read done");
		// Read and write outcomes, ending with both completions standing together
		for (int i = 0; i < 13; i++) begin
			pulse(seq_ev[i], (i == 11) ? 16'h0000 : 16'h0003);
			live(seq_st[i], 16'h0000);
		end
		$display("test events done");
		// Line errors stick until a query, which still reports them
		send(1'b1, 1'b0, 1'b0);
		send(1'b0, 1'b1, 1'b0);
		live(16'h4AE0, 16'h0002);
		query(16'h4AE0, 16'h0002);
		live(16'h4A20, 16'h0002);
		cmd(CMD_FLUSH_BUF, LEN_FLUSH_BUF, 16'h0000, 16'h0000, ERR_NONE);
		live(16'h4820, 16'h0000);
		$display("test line errors done");
		// Resize: one word over the limit, then 8 words, then overfill
		cmd(CMD_SETUP_BUF, LEN_SETUP_BUF, 16'h0401, 16'h0000, ERR_TOO_BIG);
		cap_is(16'h0800);
		cmd(CMD_SETUP_BUF, LEN_SETUP_BUF, 16'h0008, 16'h0000, ERR_NONE);
		cap_is(16'h0010);
		for (int i = 0; i < 17; i++) send(1'b0, 1'b0, 1'b0);
		live(16'h4B20, 16'h0010);
		query(16'h4B20, 16'h0010);
		live(16'h4A20, 16'h0010);
		cmd(CMD_FLUSH_BUF, LEN_FLUSH_BUF, 16'h0000, 16'h0000, ERR_NONE);
		live(16'h4820, 16'h0000);
		cmd(CMD_SETUP_BUF, LEN_SETUP_BUF, 16'h0000, 16'h0000, ERR_NONE);
		cap_is(16'h0800);
		cmd(CMD_SETUP_BUF, LEN_SETUP_BUF, 16'h0400, 16'h0000, ERR_NONE);
		cap_is(16'h0800);
		// Receiver overrun with both line errors, reported once and then cleared
		send(1'b1, 1'b1, 1'b0);
		query(16'h4BE0, 16'h0001);
		cmd(CMD_FLUSH_BUF, LEN_FLUSH_BUF, 16'h0000, 16'h0000, ERR_NONE);
		live(16'h4820, 16'h0000);
		$display("test resize done");
		// CTS dropped by the device
		@(posedge ref_clk);
		cts_in <= 1'b0;
		live(16'h4800, 16'h0000);
		$display("test cts done");
		test_done();
	end
endmodule

`default_nettype wire
